// *** hdl/cnmt_pkg.sv ***
// constants and types shared by the network-management slave files
package cnmt_pkg;
    // ========================================================
    // frame identity
    localparam logic [10:0] NMT_COB_ID      = 11'h000;
    localparam logic [3:0]  NMT_DLC         = 4'h2;
    localparam logic [6:0]  NODE_BROADCAST  = 7'h00;
    // ========================================================
    // command specifiers
    localparam logic [7:0]  CS_START        = 8'h01;
    localparam logic [7:0]  CS_STOP         = 8'h02;
    localparam logic [7:0]  CS_PREOP        = 8'h80;
    localparam logic [7:0]  CS_RESET_NODE   = 8'h81;
    localparam logic [7:0]  CS_RESET_COMM   = 8'h82;
    // ========================================================
    // node-state codes as read and written
    localparam logic [7:0]  NS_INIT         = 8'h00;
    localparam logic [7:0]  NS_STOPPED      = 8'h04;
    localparam logic [7:0]  NS_OPERATIONAL  = 8'h05;
    localparam logic [7:0]  NS_PREOP        = 8'h7F;
    localparam logic [7:0]  NS_RESET_NODE   = 8'h80;
    localparam logic [7:0]  NS_RESET_COMM   = 8'h81;
    // ========================================================
    // boot target select codes
    localparam logic [1:0]  BOOT_PREOP      = 2'h0;
    localparam logic [1:0]  BOOT_STOPPED    = 2'h1;
    localparam logic [1:0]  BOOT_OPER       = 2'h2;
    // ========================================================
    // receive channel communication objects
    localparam int          RX_CHANNELS     = 7;
    localparam logic [7:0]  SUB_COUNT       = 8'h00;
    localparam logic [7:0]  SUB_COB_ID      = 8'h01;
    localparam logic [7:0]  SUB_TTYPE       = 8'h02;
    localparam logic [31:0] SUB_COUNT_VALUE = 32'h0000_0002;
    localparam logic [31:0] RX1_ID_BASE     = 32'h0000_0200;
    localparam logic [31:0] RX2_ID_BASE     = 32'h0000_0300;
    localparam logic [31:0] RX_ID_DISABLED  = 32'h8000_06DF;
    localparam logic [7:0]  TTYPE_DEFAULT   = 8'hFE;
    localparam logic [7:0]  TTYPE_ASYNC_MAN = 8'hFE;
    localparam logic [7:0]  TTYPE_ASYNC_DEV = 8'hFF;
    localparam int          COB_INVALID_BIT = 31;
    // ========================================================
    // timing: initializing is held this many cycles plus one, covers the id synchroniser
    localparam logic [1:0]  INIT_CYCLES     = 2'h3;
    // ========================================================
    typedef enum logic [3:0] {
        ST_INIT  = 4'b0001,
        ST_PREOP = 4'b0010,
        ST_OPER  = 4'b0100,
        ST_STOP  = 4'b1000
    } cnmt_state_type;
endpackage

// *** hdl/cnmt_cmd_dec.sv ***
// decoder of two-byte network-management frames for this node
`timescale 1ns/1ps
module cnmt_cmd_dec (
    input  wire logic        rx_valid,
    input  wire logic [10:0] rx_id,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [7:0]  rx_byte0,
    input  wire logic [7:0]  rx_byte1,
    input  wire logic [6:0]  node_id,
    output logic             cmd_start,
    output logic             cmd_stop,
    output logic             cmd_preop,
    output logic             cmd_rnode,
    output logic             cmd_rcomm
);
    import cnmt_pkg::*;
    logic frame_ok;
    logic for_us;
    // fixed identifier, exactly two bytes, top node bit must be clear
    assign frame_ok  = rx_valid && rx_id == NMT_COB_ID && rx_dlc == NMT_DLC;
    assign for_us    = !rx_byte1[7] && (rx_byte1[6:0] == node_id ||
                       rx_byte1[6:0] == NODE_BROADCAST);
    // unknown specifiers fall through to no command at all
    assign cmd_start = frame_ok && for_us && rx_byte0 == CS_START;
    assign cmd_stop  = frame_ok && for_us && rx_byte0 == CS_STOP;
    assign cmd_preop = frame_ok && for_us && rx_byte0 == CS_PREOP;
    assign cmd_rnode = frame_ok && for_us && rx_byte0 == CS_RESET_NODE;
    assign cmd_rcomm = frame_ok && for_us && rx_byte0 == CS_RESET_COMM;
endmodule // cnmt_cmd_dec

// *** hdl/cnmt_rx_chan.sv ***
// one receive channel communication object: identifier and type
`timescale 1ns/1ps
module cnmt_rx_chan #(
    parameter logic [31:0] DEF_ID       = 32'h8000_06DF,
    parameter bit          DEF_ADD_NODE = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        load_def,
    input  wire logic [6:0]  node_id,
    input  wire logic        wr_id,
    input  wire logic        wr_tt,
    input  wire logic [31:0] wdata,
    output logic [31:0]      cob_id,
    output logic [7:0]       ttype
);
    import cnmt_pkg::*;
    logic [31:0] def_id;
    // node-relative defaults need the node id, so async reset parks
    // the channel disabled and load_def fills the real default later
    assign def_id = DEF_ADD_NODE ? DEF_ID + {25'h0000000, node_id} : DEF_ID;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cob_id <= RX_ID_DISABLED;
            ttype  <= TTYPE_DEFAULT;
        end else if (load_def) begin
            cob_id <= def_id;
            ttype  <= TTYPE_DEFAULT;
        end else begin
            if (wr_id) begin
                cob_id <= wdata;
            end
            if (wr_tt) begin
                ttype <= wdata[7:0];
            end
        end
    end
endmodule // cnmt_rx_chan

// *** hdl/cnmt_slave.sv ***
// network-management slave state machine with receive channel objects
// Operation
// - management frames use identifier zero, fixed and unchangeable
// - management frames carry two bytes: specifier then node id
// - power-up passes initializing, then by default pre-operational
// - boot setting may pick stopped or operational after start-up
// - pre-operational ignores process data, still serves service data
// - only operational handles process data; service data too
// - stopped handles neither process nor service data
// - stopped is left only by preop, start, reset node, reset comm; here the state write also leaves it
// - start moves pre-operational to operational
// - stop moves pre-operational or operational to stopped
// - enter-preop moves operational or stopped to pre-operational
// - reset node goes to initializing and restores all objects
// - reset comm goes to initializing and restores comm objects
// - specifier 01h start, 02h stop, 80h enter pre-operational
// - specifier 81h reset node, 82h reset communication
// - node byte 1 to 127 selects a single slave
// - node byte zero addresses all slaves; device executes it
// - state reads 0 init, 4 stopped, 5 operational, 127 preop
// - state write forces state; 128 node reset, 129 comm reset
// - channels 1-7 config by service data; subindex 0 reads 2
// - channel 1 defaults to 200h plus node id, type FEh
// - channel 2 defaults to 300h plus node id, type FEh
// - channels 3 to 7 default to 800006DFh, disabled
// - type FEh accepts process data immediately on arrival
`timescale 1ns/1ps
module cnmt_slave (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic [6:0]  NODE_ID,
    input  wire logic [1:0]  BOOT_TARGET_STATE_SELECT,
    input  wire logic        RX_VALID,
    input  wire logic [10:0] RX_ID,
    input  wire logic [3:0]  RX_DLC,
    input  wire logic [7:0]  RX_BYTE0,
    input  wire logic [7:0]  RX_BYTE1,
    input  wire logic        NODE_STATE_WR,
    input  wire logic [7:0]  NODE_STATE_WDATA,
    output logic [7:0]       NODE_STATE_CONTROL,
    input  wire logic        PDO_RX_VALID,
    input  wire logic [10:0] PDO_RX_ID,
    output logic             PDO_ACCEPT,
    output logic [2:0]       PDO_CHAN,
    output logic             PDO_TX_EN,
    output logic             SDO_EN,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [2:0]  CFG_CH,
    input  wire logic [7:0]  CFG_SUB,
    input  wire logic [31:0] CFG_WDATA,
    output logic [31:0]      CFG_RDATA,
    output logic             CFG_ACK,
    output logic             CFG_ERR,
    output logic             APP_RESET,
    output logic             COMM_RESET
);
    import cnmt_pkg::*;
    default clocking cnmt_cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    cnmt_state_type state;
    logic [6:0]  node_meta;
    logic [6:0]  node_id;
    logic [1:0]  init_cnt;
    logic        init_done;
    logic        cmd_start;
    logic        cmd_stop;
    logic        cmd_preop;
    logic        cmd_rnode;
    logic        cmd_rcomm;
    logic        any_cmd;
    logic        go_rnode;
    logic        go_rcomm;
    logic        active;
    logic        sdo_ok;
    logic        cfg_ch_ok;
    logic        cfg_sub_ok;
    logic [31:0] cob_id [RX_CHANNELS];
    logic [7:0]  ttype  [RX_CHANNELS];
    logic [RX_CHANNELS-1:0] wr_id;
    logic [RX_CHANNELS-1:0] wr_tt;
    logic [RX_CHANNELS-1:0] pdo_hit;
    logic [2:0]  hit_idx;

    // ========================================================
    // node id synchroniser
    // strap from a pin; first stage feeds only the second
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            node_meta <= 7'h00;
            node_id   <= 7'h00;
        end else begin
            node_meta <= NODE_ID;
            node_id   <= node_meta;
        end
    end

    // ========================================================
    // command decode
    cnmt_cmd_dec u_dec (
        .rx_valid  (RX_VALID),
        .rx_id     (RX_ID),
        .rx_dlc    (RX_DLC),
        .rx_byte0  (RX_BYTE0),
        .rx_byte1  (RX_BYTE1),
        .node_id   (node_id),
        .cmd_start (cmd_start),
        .cmd_stop  (cmd_stop),
        .cmd_preop (cmd_preop),
        .cmd_rnode (cmd_rnode),
        .cmd_rcomm (cmd_rcomm)
    );

    // ========================================================
    // state machine
    // a live frame wins over a state write in the same cycle
    assign active    = state != ST_INIT;
    assign any_cmd   = cmd_start || cmd_stop || cmd_preop ||
                       cmd_rnode || cmd_rcomm;
    assign go_rnode  = active && (cmd_rnode ||
                       (!any_cmd && NODE_STATE_WR &&
                        NODE_STATE_WDATA == NS_RESET_NODE));
    assign go_rcomm  = active && !go_rnode && (cmd_rcomm ||
                       (!any_cmd && NODE_STATE_WR &&
                        NODE_STATE_WDATA == NS_RESET_COMM));
    assign init_done = state == ST_INIT && init_cnt == 2'h0;

    // hold initializing a few cycles so the node id is settled
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            init_cnt <= INIT_CYCLES;
        end else if (state != ST_INIT) begin
            init_cnt <= INIT_CYCLES;
        end else if (init_cnt != 2'h0) begin
            init_cnt <= init_cnt - 2'h1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_INIT;
        end else if (go_rnode || go_rcomm) begin
            state <= ST_INIT;
        end else begin
            case (state)
                ST_INIT: begin
                    if (init_done) begin
                        case (BOOT_TARGET_STATE_SELECT)
                            BOOT_STOPPED: state <= ST_STOP;
                            BOOT_OPER:    state <= ST_OPER;
                            default:      state <= ST_PREOP;
                        endcase
                    end
                end
                ST_PREOP: begin
                    if (cmd_start) begin
                        state <= ST_OPER;
                    end else if (cmd_stop) begin
                        state <= ST_STOP;
                    end else if (!any_cmd && NODE_STATE_WR) begin
                        if (NODE_STATE_WDATA == NS_OPERATIONAL) begin
                            state <= ST_OPER;
                        end else if (NODE_STATE_WDATA == NS_STOPPED) begin
                            state <= ST_STOP;
                        end
                    end
                end
                ST_OPER: begin
                    if (cmd_stop) begin
                        state <= ST_STOP;
                    end else if (cmd_preop) begin
                        state <= ST_PREOP;
                    end else if (!any_cmd && NODE_STATE_WR) begin
                        if (NODE_STATE_WDATA == NS_PREOP) begin
                            state <= ST_PREOP;
                        end else if (NODE_STATE_WDATA == NS_STOPPED) begin
                            state <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    // only frames and the state setting get out
                    if (cmd_preop) begin
                        state <= ST_PREOP;
                    end else if (cmd_start) begin
                        state <= ST_OPER;
                    end else if (!any_cmd && NODE_STATE_WR) begin
                        if (NODE_STATE_WDATA == NS_PREOP) begin
                            state <= ST_PREOP;
                        end else if (NODE_STATE_WDATA == NS_OPERATIONAL) begin
                            state <= ST_OPER;
                        end
                    end
                end
                default: state <= ST_INIT;
            endcase
        end
    end

    // ========================================================
    // reset pulses and state readback
    // one-cycle pulses on entry to initializing
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            APP_RESET  <= 1'b0;
            COMM_RESET <= 1'b0;
        end else begin
            APP_RESET  <= go_rnode;
            COMM_RESET <= go_rnode || go_rcomm;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            NODE_STATE_CONTROL <= NS_INIT;
        end else begin
            case (state)
                ST_PREOP: NODE_STATE_CONTROL <= NS_PREOP;
                ST_OPER:  NODE_STATE_CONTROL <= NS_OPERATIONAL;
                ST_STOP:  NODE_STATE_CONTROL <= NS_STOPPED;
                default:  NODE_STATE_CONTROL <= NS_INIT;
            endcase
        end
    end

    // ========================================================
    // service enables
    assign sdo_ok = state == ST_PREOP || state == ST_OPER;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            SDO_EN    <= 1'b0;
            PDO_TX_EN <= 1'b0;
        end else begin
            SDO_EN    <= sdo_ok;
            PDO_TX_EN <= state == ST_OPER;
        end
    end

    // ========================================================
    // receive channel objects
    // defaults reload at the end of every pass through initializing,
    // which covers power-up and both reset commands
    assign cfg_ch_ok  = CFG_CH < 3'(RX_CHANNELS);
    assign cfg_sub_ok = CFG_SUB == SUB_COUNT || CFG_SUB == SUB_COB_ID ||
                        CFG_SUB == SUB_TTYPE;
    genvar g;
    generate
        for (g = 0; g < RX_CHANNELS; g = g + 1) begin : g_ch
            localparam logic [31:0] DEF = (g == 0) ? RX1_ID_BASE :
                                          (g == 1) ? RX2_ID_BASE :
                                          RX_ID_DISABLED;
            assign wr_id[g] = CFG_WR && sdo_ok && CFG_CH == 3'(g) &&
                              CFG_SUB == SUB_COB_ID;
            assign wr_tt[g] = CFG_WR && sdo_ok && CFG_CH == 3'(g) &&
                              CFG_SUB == SUB_TTYPE;
            cnmt_rx_chan #(
                .DEF_ID       (DEF),
                .DEF_ADD_NODE (g < 2)
            ) u_chan (
                .clk      (SYS_CLK),
                .rst      (RESET),
                .load_def (init_done),
                .node_id  (node_id),
                .wr_id    (wr_id[g]),
                .wr_tt    (wr_tt[g]),
                .wdata    (CFG_WDATA),
                .cob_id   (cob_id[g]),
                .ttype    (ttype[g])
            );
            // valid, matching, asynchronous type only
            assign pdo_hit[g] = !cob_id[g][COB_INVALID_BIT] &&
                                cob_id[g][10:0] == PDO_RX_ID &&
                                (ttype[g] == TTYPE_ASYNC_MAN ||
                                 ttype[g] == TTYPE_ASYNC_DEV);
        end
    endgenerate

    // configuration answer, one cycle after the strobe
    // subindex 0 is fixed at two and refuses writes
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            CFG_RDATA <= 32'h0000_0000;
            CFG_ACK   <= 1'b0;
            CFG_ERR   <= 1'b0;
        end else begin
            CFG_ACK <= CFG_WR || CFG_RD;
            CFG_ERR <= (CFG_WR || CFG_RD) && (!sdo_ok || !cfg_ch_ok ||
                       !cfg_sub_ok || (CFG_WR && CFG_SUB == SUB_COUNT));
            if (CFG_RD && sdo_ok && cfg_ch_ok) begin
                if (CFG_SUB == SUB_COUNT) begin
                    CFG_RDATA <= SUB_COUNT_VALUE;
                end else if (CFG_SUB == SUB_COB_ID) begin
                    CFG_RDATA <= cob_id[CFG_CH];
                end else if (CFG_SUB == SUB_TTYPE) begin
                    CFG_RDATA <= {24'h000000, ttype[CFG_CH]};
                end else begin
                    CFG_RDATA <= 32'h0000_0000;
                end
            end else if (CFG_RD) begin
                CFG_RDATA <= 32'h0000_0000;
            end
        end
    end

    // ========================================================
    // process data acceptance
    // lowest channel wins if two share an identifier
    always_comb begin
        hit_idx = 3'h0;
        for (int i = RX_CHANNELS - 1; i >= 0; i--) begin
            if (pdo_hit[i]) begin
                hit_idx = 3'(i);
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            PDO_ACCEPT <= 1'b0;
            PDO_CHAN   <= 3'h0;
        end else begin
            PDO_ACCEPT <= PDO_RX_VALID && state == ST_OPER &&
                          |pdo_hit;
            if (PDO_RX_VALID && state == ST_OPER && |pdo_hit) begin
                PDO_CHAN <= hit_idx;
            end
        end
    end

    // ========================================================
    // checks
    a_boot_preop: assert property (
        init_done && BOOT_TARGET_STATE_SELECT == BOOT_PREOP && !go_rnode
        |=> state == ST_PREOP ##1 NODE_STATE_CONTROL == NS_PREOP)
        else $error("boot did not reach pre-operational");
    a_start_oper: assert property (
        state == ST_PREOP && cmd_start |=> state == ST_OPER ##1 PDO_TX_EN)
        else $error("start did not reach operational");
    a_stop_cmd: assert property (
        (state == ST_PREOP || state == ST_OPER) && cmd_stop
        |=> state == ST_STOP ##1 !SDO_EN)
        else $error("stop not honoured");
    a_preop_cmd: assert property (
        (state == ST_OPER || state == ST_STOP) && cmd_preop
        |=> state == ST_PREOP)
        else $error("enter pre-operational not honoured");
    a_node_reset: assert property (
        active && cmd_rnode |=> state == ST_INIT && APP_RESET && COMM_RESET)
        else $error("reset node missing");
    a_comm_reset: assert property (
        active && cmd_rcomm |=> state == ST_INIT && !APP_RESET && COMM_RESET)
        else $error("reset communication wrong");
    a_stop_quiet: assert property (
        state == ST_STOP && $past(state) == ST_STOP |-> !SDO_EN && !PDO_ACCEPT)
        else $error("stopped node still serving");
    a_pdo_oper: assert property (
        PDO_ACCEPT |-> $past(state) == ST_OPER)
        else $error("process data outside operational");
    a_foreign_node: assert property (
        RX_VALID && RX_BYTE1[6:0] != node_id && RX_BYTE1 != 8'h00 &&
        !NODE_STATE_WR && !init_done |=> $stable(state))
        else $error("foreign command acted on");
    c_boot: cover property (@(posedge SYS_CLK) init_done ##1 state == ST_PREOP);
    c_start: cover property (@(posedge SYS_CLK) cmd_start ##1 state == ST_OPER);
    c_accept: cover property (@(posedge SYS_CLK) PDO_ACCEPT);
    c_reset: cover property (@(posedge SYS_CLK) APP_RESET);
endmodule // cnmt_slave

// *** bench/cnmt_master_model.sv ***
// management master model driving two-byte frames
`timescale 1ns/1ps
module cnmt_master_model (
    input  wire logic   clk,
    output logic        v,
    output logic [10:0] id,
    output logic [3:0]  n,
    output logic [7:0]  cs,
    output logic [7:0]  nd
);
    // ==========
    // frames; released id, specifier and node lines go inverted, length is held, so stale data never matches
    initial {v, id, n, cs, nd} = '0;
    task automatic send(input logic [10:0] i, input logic [3:0] l,
                        input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        {v, id, n, cs, nd} <= {1'b1, i, l, c, d};
        @(posedge clk);
        {v, id, cs, nd} <= {1'b0, ~i, ~c, ~d};
    endtask
endmodule // cnmt_master_model

// *** bench/cnmt_slave_tb.sv ***
// bench for the management slave
`timescale 1ns/1ps
module cnmt_slave_tb;
    import cnmt_pkg::*;
    localparam logic [7:0] nd = 8'h05;
    logic clk = 0, rst = 1, nw = 0, pv = 0, cw = 0, cr = 0;
    logic [1:0] bs = BOOT_PREOP;
    logic [7:0] nwd = '0, sub = '0;
    logic [2:0] ch = '0;
    logic [10:0] pid = '0;
    logic [31:0] wd = '0, want;
    wire logic v, ack, err, ar, cm, pa, tx, sdo;
    wire logic [10:0] id;
    wire logic [3:0] n;
    wire logic [7:0] cs, b1, ns;
    wire logic [2:0] pc;
    wire logic [31:0] rd;
    int failures = 0, samples_checked = 0;
    // ==========
    // clock, far side and device
    always #5 clk = ~clk;
    cnmt_master_model u_master (.clk(clk), .v(v), .id(id), .n(n), .cs(cs),
        .nd(b1));
    cnmt_slave u_dut (.SYS_CLK(clk), .RESET(rst), .NODE_ID(nd[6:0]),
        .BOOT_TARGET_STATE_SELECT(bs), .RX_VALID(v), .RX_ID(id),
        .RX_DLC(n), .RX_BYTE0(cs), .RX_BYTE1(b1), .NODE_STATE_WR(nw),
        .NODE_STATE_WDATA(nwd), .NODE_STATE_CONTROL(ns), .PDO_RX_VALID(pv),
        .PDO_RX_ID(pid), .PDO_ACCEPT(pa), .PDO_CHAN(pc), .PDO_TX_EN(tx),
        .SDO_EN(sdo), .CFG_WR(cw), .CFG_RD(cr), .CFG_CH(ch), .CFG_SUB(sub),
        .CFG_WDATA(wd), .CFG_RDATA(rd), .CFG_ACK(ack), .CFG_ERR(err),
        .APP_RESET(ar), .COMM_RESET(cm));
    task automatic close_out;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // readback lags the state, so skip two edges before polling
    task automatic wait_ns(input logic [7:0] e);
        tick(2);
        for (int i = 0; i < 20 && ns !== e; i++)
            tick(1);
        check(ns, e);
        if (ns !== e)
            close_out();
    endtask
    task automatic cfg(input logic w, input int c, input logic [7:0] s,
        input logic [31:0] d, input logic [31:0] e, input logic r);
        @(posedge clk);
        {cw, cr, ch, sub, wd} <= {w, !w, c[2:0], s, d};
        @(posedge clk);
        {cw, cr} <= 2'b00;
        // answer stands for the one cycle after the taking edge
        #1;
        check(ack, 1);
        check(err, r);
        if (!w)
            check(rd, e);
    endtask
    task automatic pdo(input logic [10:0] i, input logic e, input int c);
        @(posedge clk);
        {pv, pid} <= {1'b1, i};
        @(posedge clk);
        {pv, pid} <= {1'b0, ~i};
        #1;
        check(pa, e);
        if (e)
            check(pc, c);
    endtask
    task automatic nmt(input logic [7:0] c, input logic [7:0] d);
        u_master.send(NMT_COB_ID, NMT_DLC, c, d);
    endtask
    task automatic nsw(input logic [7:0] d);
        @(posedge clk);
        {nw, nwd} <= {1'b1, d};
        @(posedge clk);
        nw <= 1'b0;
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wait_ns(NS_PREOP);
        check(sdo, 1);
        for (int c = 0; c < RX_CHANNELS; c++) begin
            want = (c > 1) ? RX_ID_DISABLED :
                   (c ? RX2_ID_BASE : RX1_ID_BASE) + nd;
            cfg(0, c, SUB_COUNT, 0, SUB_COUNT_VALUE, 0);
            cfg(0, c, SUB_TTYPE, 0, TTYPE_DEFAULT, 0);
            cfg(0, c, SUB_COB_ID, 0, want, 0);
        end
        cfg(1, 2, SUB_COUNT, 5, 0, 1);
        cfg(1, 2, SUB_COB_ID, 32'h123, 0, 0);
        cfg(0, 2, SUB_COB_ID, 0, 32'h123, 0);
        pdo(11'h205, 0, 0);
        nmt(CS_START, 8'h00);
        wait_ns(NS_OPERATIONAL);
        check(tx, 1);
        pdo(11'h205, 1, 0);
        pdo(11'h123, 1, 2);
        u_master.send(11'h001, NMT_DLC, CS_STOP, nd);
        u_master.send(NMT_COB_ID, 4'h3, CS_STOP, nd);
        nmt(CS_STOP, 8'h06);
        nmt(8'h03, nd);
        wait_ns(NS_OPERATIONAL);
        nmt(CS_STOP, nd);
        wait_ns(NS_STOPPED);
        check(sdo, 0);
        cfg(0, 0, SUB_COB_ID, 0, 0, 1);
        pdo(11'h205, 0, 0);
        nmt(CS_PREOP, nd);
        wait_ns(NS_PREOP);
        // reset pulses stand in the cycle after the taking edge
        nmt(CS_RESET_NODE, nd);
        #1;
        check({ar, cm}, 2'b11);
        wait_ns(NS_PREOP);
        cfg(0, 2, SUB_COB_ID, 0, RX_ID_DISABLED, 0);
        // dirty channel 2 again so the comm reset has work to undo
        cfg(1, 2, SUB_COB_ID, 32'h123, 0, 0);
        nmt(CS_RESET_COMM, nd);
        #1;
        check({ar, cm}, 2'b01);
        wait_ns(NS_PREOP);
        cfg(0, 2, SUB_COB_ID, 0, RX_ID_DISABLED, 0);
        nsw(NS_OPERATIONAL);
        wait_ns(NS_OPERATIONAL);
        nsw(NS_INIT);
        wait_ns(NS_OPERATIONAL);
        nsw(NS_STOPPED);
        wait_ns(NS_STOPPED);
        nmt(CS_START, 8'h00);
        wait_ns(NS_OPERATIONAL);
        nsw(NS_PREOP);
        wait_ns(NS_PREOP);
        @(posedge clk);
        bs <= BOOT_STOPPED;
        nsw(NS_RESET_COMM);
        wait_ns(NS_STOPPED);
        @(posedge clk);
        bs <= BOOT_OPER;
        nsw(NS_RESET_NODE);
        #1;
        check({ar, cm}, 2'b11);
        wait_ns(NS_OPERATIONAL);
        close_out();
    end
endmodule // cnmt_slave_tb
